// ==== include/tkd_params.svh ====
// constants for the touch key detection block: offsets, fields, timings
`ifndef TKD_PARAMS_SVH
`define TKD_PARAMS_SVH

// register byte offsets on the wishbone slave
`define TKD_ADR_CTRL 8'h00
`define TKD_ADR_STATUS 8'h04
`define TKD_ADR_BASE0 8'h10

// control register fields
`define TKD_CTRL_FALL_LSB 0
`define TKD_CTRL_RISE_LSB 8
`define TKD_CTRL_RECAL_BIT 16

// status register fields
`define TKD_STAT_OUT_LSB 0
`define TKD_STAT_ACT_LSB 8
`define TKD_STAT_MODE_LSB 16
`define TKD_STAT_DRIVE_BIT 20
`define TKD_STAT_SUPP_BIT 21

// drift divider reset values, in samples per reference step
`define TKD_FALL_DIV_RST 8'h02
`define TKD_RISE_DIV_RST 8'h14

// detection levels in signal counts, and the integrator limit in samples
`define TKD_THRESH 16'h0006
`define TKD_HYST 16'h0002
`define TKD_INTEG_LIMIT 2'h3

// timing: the clock, and the nominal acquisition cycle
`define TKD_CLK_NS 25
`define TKD_RESP_REF_NS 99000000
`define TKD_REF_CLK_NS 100
`define TKD_ACQ_CLKS (`TKD_RESP_REF_NS / `TKD_REF_CLK_NS / 3)
`define TKD_ACQ_US (`TKD_ACQ_CLKS * `TKD_CLK_NS / 1000)
`define TKD_TO_SHORT_S 10
`define TKD_TO_LONG_S 60
`define TKD_TO_SHORT_CYC (`TKD_TO_SHORT_S * 1000000 / `TKD_ACQ_US)
`define TKD_TO_LONG_CYC (`TKD_TO_LONG_S * 1000000 / `TKD_ACQ_US)

`endif

// ==== include/tkd_pkg.sv ====
// types shared by the touch key detection block
package tkd_pkg;

  // output mode and timeout selection, one-hot
  typedef enum logic [3:0]
  {
    TKD_MODE_DC_INF = 4'h1,
    TKD_MODE_DC_10 = 4'h2,
    TKD_MODE_DC_60 = 4'h4,
    TKD_MODE_TOGGLE = 4'h8
  } tkd_mode_e;

  typedef logic [15:0] tkd_word_t;
  typedef logic signed [16:0] tkd_diff_t;

endpackage

// ==== rtl/tkd_detect.sv ====
// touch key detection: drift, threshold, integrator, timeout and outputs
`timescale 1ns/1ps
`include "tkd_params.svh"

// Behaviour
// R1 - signals are sixteen bit wide; differences are seventeen bit signed
// R2 - sample is over threshold when signal exceeds reference by six
// R3 - detection holds until signal drops more than two counts below threshold
// R4 - threshold and hysteresis levels follow each channel's reference
// R5 - reference slews toward signal per channel, only with no detection
// R6 - reference falls faster than it rises
// R7 - integrator counts over-threshold samples, clears otherwise, fires at 3
// R8 - active detection is timed; expiry forces full recalibration
// R9 - each channel has its own timer and recalibration
// R10 - straps pick 10 s, 60 s or infinite, derived from the clock
// R11 - timeouts count acquisition cycles, so slow bursts stretch them
// R12 - all channels recalibrate after power-up; reset pin is active low
// R13 - a host pulses the reset pin low about 5 us to force recalibration
// R14 - response is three acquisition cycles, scaling with clock rate
// R15 - straps are sampled once per acquisition cycle, live changes apply
// R16 - output mode straps apply to every channel alike
// R17 - dc mode follows detection; timeout recalibrates and drops output
// R18 - toggle mode flips output per detection, timeout fixed at 10 s
// R19 - toggle mode timeout recalibrates but keeps the output state
// R20 - drive strap low gives push-pull active-high outputs
// R21 - drive strap high gives open-drain active-low outputs
// R22 - strap decode: 01 dc 10 s, 10 dc 60 s, 11 toggle, 00 dc infinite
// R23 - suppression strap high enables key suppression
// R24 - before activation, block if another key is active or stronger
// R25 - channels are processed in fixed order, once per acquisition cycle
// R26 - recalibration loads signal into reference, clears integrator and timer
module tkd_detect
#(
  parameter int NCH = 5,
  parameter int TO_SHORT_CYC = `TKD_TO_SHORT_CYC,
  parameter int TO_LONG_CYC = `TKD_TO_LONG_CYC
)
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // samples from the acquisition front end, same clock
  input wire logic sample_valid_i,
  input wire logic [((NCH > 1) ? $clog2(NCH) : 1)-1:0] sample_ch_i,
  input wire logic [15:0] sample_i,
  // strap and reset pins, asynchronous
  input wire logic output_mode_strap_a_i,
  input wire logic output_mode_strap_b_i,
  input wire logic drive_type_strap_i,
  input wire logic key_suppress_strap_i,
  input wire logic recal_n_i,
  // key outputs, per channel
  output logic [NCH-1:0] key_o,
  output logic [NCH-1:0] key_oe_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  if (NCH < 1 || NCH > 8 || TO_SHORT_CYC < 1 || TO_SHORT_CYC > 65535
      || TO_LONG_CYC < 1 || TO_LONG_CYC > 65535)
  begin : g_bad_params
    $error("tkd_detect: unsupported channel count or timeout");
  end

  //////////////////////////////////////////////////////////////////////////
  // per-channel state, flip-flops indexed by channel, and the last channel processed
  tkd_pkg::tkd_word_t base_q [NCH];
  tkd_pkg::tkd_word_t timer_q [NCH];
  tkd_pkg::tkd_diff_t delta_q [NCH];
  logic [1:0] integ_q [NCH];
  logic [7:0] drift_q [NCH];
  logic [NCH-1:0] act_q;
  logic [NCH-1:0] out_q;
  logic [NCH-1:0] pend_q;
  logic [CW-1:0] lch_q;

  // shared settings
  tkd_pkg::tkd_mode_e mode_q;
  logic drive_q;
  logic supp_q;
  logic [7:0] fall_div_q;
  logic [7:0] rise_div_q;
  logic sw_recal;

  // pin synchronisers
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;

  // current-sample decode
  logic proc;
  logic cyc_end;
  logic [CW-1:0] ch;
  tkd_pkg::tkd_word_t cur_base;
  tkd_pkg::tkd_diff_t diff;
  tkd_pkg::tkd_diff_t thr_lvl;
  tkd_pkg::tkd_diff_t keep_lvl;
  logic over;
  logic keep;
  logic act_c;
  logic tmo_c;
  logic blocked;
  logic toggle;
  tkd_pkg::tkd_word_t lim;
  tkd_pkg::tkd_mode_e next_mode;

  //////////////////////////////////////////////////////////////////////////
  // two flops on every pin before anything reads it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1 <= 5'h10;
      pin_s2 <= 5'h10;
    end
    else if (ce_i)
    begin
      pin_s1 <= {recal_n_i, key_suppress_strap_i, drive_type_strap_i,
                 output_mode_strap_b_i, output_mode_strap_a_i};
      pin_s2 <= pin_s1; // R13
    end
  end

  // strap decode for the shared output mode
  always_comb
  begin
    case (pin_s2[1:0])
      2'b10: next_mode = tkd_pkg::TKD_MODE_DC_10; // R22
      2'b01: next_mode = tkd_pkg::TKD_MODE_DC_60; // R22
      2'b11: next_mode = tkd_pkg::TKD_MODE_TOGGLE; // R22
      default: next_mode = tkd_pkg::TKD_MODE_DC_INF; // R22
    endcase
  end

  // straps latched once per acquisition cycle; drive resets to released
  // open drain so no pin is driven before the straps have been read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= tkd_pkg::TKD_MODE_DC_INF;
      drive_q <= 1'b1;
      supp_q <= 1'b0;
    end
    else if (ce_i && cyc_end)
    begin
      mode_q <= next_mode; // R15 R16
      drive_q <= pin_s2[2]; // R15
      supp_q <= pin_s2[3]; // R23
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // decode of the sample being processed this cycle
  assign proc = ce_i && sample_valid_i && (sample_ch_i < NCH);
  assign ch = sample_ch_i;
  assign cyc_end = proc && (ch == CW'(NCH - 1)); // R25
  assign cur_base = base_q[ch];
  assign diff = $signed({1'b0, sample_i}) - $signed({1'b0, cur_base}); // R1
  assign thr_lvl = $signed({1'b0, `TKD_THRESH});
  assign keep_lvl = $signed({1'b0, `TKD_THRESH - `TKD_HYST});
  assign over = diff >= thr_lvl; // R2 R4
  assign keep = diff >= keep_lvl; // R3 R4
  assign act_c = act_q[ch];
  assign toggle = mode_q == tkd_pkg::TKD_MODE_TOGGLE;

  // timeout limit in acquisition cycles; zero means never
  always_comb
  begin
    case (mode_q)
      tkd_pkg::TKD_MODE_DC_10: lim = 16'(TO_SHORT_CYC); // R10
      tkd_pkg::TKD_MODE_DC_60: lim = 16'(TO_LONG_CYC); // R10
      tkd_pkg::TKD_MODE_TOGGLE: lim = 16'(TO_SHORT_CYC); // R18
      default: lim = 16'h0000;
    endcase
  end

  assign tmo_c = act_c && (lim != 16'h0000) && (timer_q[ch] >= lim); // R8

  // suppression looks at every other key, active or stronger
  always_comb
  begin
    blocked = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      if (CW'(i) != ch && (act_q[i] || delta_q[i] > diff))
      begin
        blocked = supp_q; // R24
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-channel processing: recalibration, hysteresis, integrator, drift
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        base_q[i] <= 16'h0000;
        timer_q[i] <= 16'h0000;
        delta_q[i] <= 17'h00000;
        integ_q[i] <= 2'h0;
        drift_q[i] <= 8'h00;
      end
      act_q <= '0;
      out_q <= '0;
      pend_q <= '1; // R12
      lch_q <= '0;
    end
    else if (ce_i)
    begin
      // timers tick once per acquisition cycle, so they stretch with it
      if (cyc_end)
      begin
        for (int i = 0; i < NCH; i++)
        begin
          if (act_q[i] && timer_q[i] != 16'hffff
              && (lim == 16'h0000 || timer_q[i] < lim))
          begin
            timer_q[i] <= timer_q[i] + 16'h0001; // R9 R11
          end
        end
      end
      if (proc)
      begin
        lch_q <= ch;
        delta_q[ch] <= diff;
        pend_q[ch] <= 1'b0;
        if (pend_q[ch] || tmo_c)
        begin
          base_q[ch] <= sample_i; // R26
          integ_q[ch] <= 2'h0; // R26
          timer_q[ch] <= 16'h0000; // R26
          drift_q[ch] <= 8'h00;
          act_q[ch] <= 1'b0; // R8 R26
          if (!toggle) // R19
          begin
            out_q[ch] <= 1'b0; // R17
          end
        end
        else if (act_c)
        begin
          // no drift while detecting
          if (!keep)
          begin
            act_q[ch] <= 1'b0; // R3
            integ_q[ch] <= 2'h0;
            timer_q[ch] <= 16'h0000;
            if (!toggle)
            begin
              out_q[ch] <= 1'b0; // R17
            end
          end
          else if (!toggle)
          begin
            out_q[ch] <= 1'b1; // R17
          end
        end
        else if (over)
        begin
          if (integ_q[ch] == `TKD_INTEG_LIMIT - 2'h1)
          begin
            // a blocked key waits at the brink until the others let go
            if (!blocked)
            begin
              integ_q[ch] <= `TKD_INTEG_LIMIT; // R7
              act_q[ch] <= 1'b1; // R7 R14
              timer_q[ch] <= 16'h0000;
              out_q[ch] <= toggle ? ~out_q[ch] : 1'b1; // R17 R18
            end
          end
          else
          begin
            integ_q[ch] <= integ_q[ch] + 2'h1; // R7
          end
        end
        else
        begin
          integ_q[ch] <= 2'h0; // R7
          if (!toggle)
          begin
            out_q[ch] <= 1'b0;
          end
          // slow rise so an approaching finger is not tracked away
          if (diff > 17'sh00000)
          begin
            if (drift_q[ch] + 8'h01 >= rise_div_q)
            begin
              base_q[ch] <= cur_base + 16'h0001; // R5 R6
              drift_q[ch] <= 8'h00;
            end
            else
            begin
              drift_q[ch] <= drift_q[ch] + 8'h01;
            end
          end
          else if (diff < 17'sh00000)
          begin
            if (drift_q[ch] + 8'h01 >= fall_div_q)
            begin
              base_q[ch] <= cur_base - 16'h0001; // R5 R6
              drift_q[ch] <= 8'h00;
            end
            else
            begin
              drift_q[ch] <= drift_q[ch] + 8'h01;
            end
          end
          else
          begin
            drift_q[ch] <= 8'h00;
          end
        end
      end
      // a recalibration request wins over the clear above
      if (!pin_s2[4] || sw_recal)
      begin
        pend_q <= '1; // R12 R13
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output drive: push-pull active high or open drain active low
  for (genvar g = 0; g < NCH; g++)
  begin : g_drive
    assign key_o[g] = drive_q ? 1'b0 : out_q[g]; // R20 R21
    assign key_oe_o[g] = drive_q ? out_q[g] : 1'b1; // R20 R21
  end

  //////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, writes land on the ack edge
  logic [31:0] rd_data;
  logic [5:0] base_idx;
  logic wr_now;

  assign base_idx = wb_adr_i[7:2] - 6'(`TKD_ADR_BASE0 >> 2);
  assign wr_now = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  assign sw_recal = wr_now && wb_adr_i == `TKD_ADR_CTRL && wb_sel_i[2]
                    && wb_dat_i[`TKD_CTRL_RECAL_BIT];

  // read mux; unmapped words read zero
  always_comb
  begin
    rd_data = 32'h00000000;
    if (wb_adr_i == `TKD_ADR_CTRL)
    begin
      rd_data[`TKD_CTRL_FALL_LSB +: 8] = fall_div_q;
      rd_data[`TKD_CTRL_RISE_LSB +: 8] = rise_div_q;
    end
    else if (wb_adr_i == `TKD_ADR_STATUS)
    begin
      rd_data[`TKD_STAT_OUT_LSB +: NCH] = out_q;
      rd_data[`TKD_STAT_ACT_LSB +: NCH] = act_q;
      rd_data[`TKD_STAT_MODE_LSB +: 4] = mode_q;
      rd_data[`TKD_STAT_DRIVE_BIT] = drive_q;
      rd_data[`TKD_STAT_SUPP_BIT] = supp_q;
    end
    else if (wb_adr_i[1:0] == 2'b00 && wb_adr_i >= `TKD_ADR_BASE0
             && base_idx < NCH)
    begin
      rd_data[15:0] = base_q[base_idx[CW-1:0]];
    end
  end

  // ack and read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // drift dividers, written per byte lane
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fall_div_q <= `TKD_FALL_DIV_RST;
      rise_div_q <= `TKD_RISE_DIV_RST;
    end
    else if (ce_i && wr_now && wb_adr_i == `TKD_ADR_CTRL)
    begin
      if (wb_sel_i[0])
      begin
        fall_div_q <= wb_dat_i[`TKD_CTRL_FALL_LSB +: 8]; // R6
      end
      if (wb_sel_i[1])
      begin
        rise_div_q <= wb_dat_i[`TKD_CTRL_RISE_LSB +: 8]; // R6
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  AST_OVER_COUNTS: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    proc && !pend_q[ch] && !tmo_c && !act_c && over
    |=> integ_q[lch_q] != 2'h0)
    else $error("over-threshold sample did not count");

  AST_INTEG_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    proc && !pend_q[ch] && !act_c && !over |=> integ_q[lch_q] == 2'h0)
    else $error("integrator not cleared on quiet sample");

  AST_HYST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    proc && !pend_q[ch] && act_c && !tmo_c && keep |=> act_q[lch_q])
    else $error("detection dropped above hysteresis level");

  AST_NO_DRIFT: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    proc && !pend_q[ch] && act_c && !tmo_c
    |=> base_q[lch_q] == $past(cur_base))
    else $error("reference moved during detection");

  AST_RECAL_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // R26
    proc && pend_q[ch]
    |=> base_q[lch_q] == $past(sample_i) && integ_q[lch_q] == 2'h0
        && !act_q[lch_q] && timer_q[lch_q] == 16'h0000)
    else $error("recalibration incomplete");

  AST_SUPPRESS: assert property (@(posedge clk_i) disable iff (rst_i) // R24
    proc && supp_q && !pend_q[ch] && !act_c && (|(act_q)) |=> !act_q[lch_q])
    else $error("key activated while another was active");

  AST_DC_TIMEOUT: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    proc && !pend_q[ch] && tmo_c && !toggle
    |=> !out_q[lch_q] && !act_q[lch_q])
    else $error("dc output held after timeout");

  AST_TOGGLE_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    proc && tmo_c && toggle |=> out_q[lch_q] == $past(out_q[ch]))
    else $error("toggle output changed on timeout");

  AST_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    drive_q |-> key_o == '0 && key_oe_o == out_q)
    else $error("open drain drive wrong");

  AST_POWERUP: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    $past(rst_i) |-> pend_q == '1 && act_q == '0)
    else $error("channels not marked for recalibration");

endmodule

// ==== tb/tb_tkd_detect.sv ====
// self-checking bench for the touch key detection block
`timescale 1ns/1ps
module tb_tkd_detect;
  localparam int NCH = 5;
  localparam logic [15:0] REF = 16'h03e8;
  // design inputs, all driven from time zero
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic sample_valid_i = 1'b0;
  logic [2:0] sample_ch_i = 3'h0;
  logic [15:0] sample_i = 16'h0000;
  logic output_mode_strap_a_i = 1'b0;
  logic output_mode_strap_b_i = 1'b0;
  logic drive_type_strap_i = 1'b0;
  logic key_suppress_strap_i = 1'b0;
  logic recal_n_i;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  // design outputs and resolved pins
  logic [NCH-1:0] key_o;
  logic [NCH-1:0] key_oe_o;
  logic [NCH-1:0] pin_o;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  // bench state
  logic [15:0] smp [NCH];
  logic [31:0] rd;
  logic [3:0] wsel = 4'hf;
  int fail_count = 0;
  int checked = 0;

  ////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  // timeouts shortened to 4 and 8 acquisition cycles
  tkd_detect #(.NCH(NCH), .TO_SHORT_CYC(4), .TO_LONG_CYC(8)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .sample_valid_i(sample_valid_i), .sample_ch_i(sample_ch_i),
    .sample_i(sample_i), .output_mode_strap_a_i(output_mode_strap_a_i),
    .output_mode_strap_b_i(output_mode_strap_b_i),
    .drive_type_strap_i(drive_type_strap_i),
    .key_suppress_strap_i(key_suppress_strap_i), .recal_n_i(recal_n_i),
    .key_o(key_o), .key_oe_o(key_oe_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  // load and host on the key side
  tkd_load_model #(.NCH(NCH)) i_load (.clk_i(clk_i), .key_i(key_o),
    .key_oe_i(key_oe_o), .pin_o(pin_o), .recal_n_o(recal_n_i));

  ////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare one value, case equality so unknowns never match a known value
  task automatic chk(input string w, input logic [31:0] got,
    input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", w, exp, got);
      fail_count++;
    end
  endtask

  // classic single wishbone cycle; held until ack is sampled high, at most 20 clocks
  task automatic wb(input logic we, input logic [7:0] adr,
    input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= wsel;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      fail_count++;
      summarize();
    end
  endtask

  // read a register and compare the masked field
  task automatic rdc(input string w, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(w, rd & m, e);
  endtask

  // n acquisition cycles, channels in fixed order, back to back
  task automatic acq(input int n);
    repeat (n)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        @(posedge clk_i);
        sample_valid_i <= 1'b1;
        sample_ch_i <= 3'(c);
        sample_i <= smp[c];
      end
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // change straps; they take effect at the next cycle end
  task automatic straps(input logic a, input logic b, input logic d,
    input logic s);
    @(posedge clk_i);
    output_mode_strap_a_i <= a;
    output_mode_strap_b_i <= b;
    drive_type_strap_i <= d;
    key_suppress_strap_i <= s;
    acq(1);
  endtask

  // hold a key until the timer expires one cycle after the limit
  task automatic stuck(input int ch, input int lim, input logic pin);
    logic [31:0] m;
    m = 32'h1 << (8 + ch);
    smp[ch] = REF + 16'h000a;
    acq(lim + 2);
    rdc("held", 8'h04, m, m);
    acq(1);
    rdc("expired", 8'h04, m, 32'h0);
    rdc("reloaded", 8'h10 + 8'(4 * ch), 32'hffff, 32'(smp[ch]));
    chk("pin after expiry", 32'(pin_o[ch]), 32'(pin));
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    foreach (smp[c])
      smp[c] = REF;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    acq(1);
    rdc("ref0", 8'h10, 32'hffff, 32'(REF));
    rdc("ctrl reset", 8'h00, 32'hffffffff, 32'h00001402);
    rdc("unmapped", 8'h08, 32'hffffffff, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      straps(i[1], i[0], i[0], i[1]);
      rdc("straps", 8'h04, 32'h003f0000,
        (32'h1 << (16 + i)) | (32'(i) << 20));
    end
    straps(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test power-up and straps done");
    // threshold and integrator on channel 0
    smp[0] = REF + 16'h0005;
    acq(3);
    chk("five over", 32'(pin_o[0]), 32'h0);
    smp[0] = REF + 16'h0006;
    acq(2);
    smp[0] = REF;
    acq(1);
    smp[0] = REF + 16'h0006;
    acq(2);
    chk("broken run", 32'(pin_o[0]), 32'h0);
    acq(1);
    chk("third sample", 32'(pin_o[0]), 32'h1);
    chk("push-pull oe", 32'(key_oe_o), 32'h1f);
    smp[0] = REF + 16'h000a;
    acq(24);
    rdc("frozen ref", 8'h10, 32'hffff, 32'(REF));
    chk("no timeout", 32'(pin_o[0]), 32'h1);
    smp[0] = REF + 16'h0004;
    acq(1);
    chk("hysteresis hold", 32'(pin_o[0]), 32'h1);
    smp[0] = REF + 16'h0003;
    acq(1);
    chk("hysteresis drop", 32'(pin_o[0]), 32'h0);
    smp[0] = REF;
    $display("test threshold done");
    // drift on channel 1 with short dividers
    wb(1'b1, 8'h00, 32'h00000402);
    smp[1] = REF + 16'h0002;
    acq(4);
    rdc("rise drift", 8'h14, 32'hffff, 32'(REF + 16'h0001));
    smp[1] = REF + 16'h0006;
    acq(3);
    chk("moved level", 32'(pin_o[1]), 32'h0);
    smp[1] = REF + 16'h0007;
    acq(3);
    chk("moved level hit", 32'(pin_o[1]), 32'h1);
    smp[1] = REF + 16'h0001;
    acq(1);
    smp[1] = REF - 16'h000a;
    acq(2);
    rdc("fall drift", 8'h14, 32'hffff, 32'(REF));
    smp[1] = REF;
    $display("test drift done");
    // stuck-key timeouts in the dc 10 s, dc 60 s and toggle modes
    straps(1'b0, 1'b1, 1'b0, 1'b0);
    stuck(0, 4, 1'b0);
    rdc("other channel", 8'h14, 32'hffff, 32'(REF));
    straps(1'b1, 1'b0, 1'b0, 1'b0);
    stuck(3, 8, 1'b0);
    straps(1'b1, 1'b1, 1'b0, 1'b0);
    smp[2] = REF + 16'h0006;
    acq(3);
    chk("toggle on", 32'(pin_o[2]), 32'h1);
    smp[2] = REF;
    acq(1);
    chk("toggle held", 32'(pin_o[2]), 32'h1);
    smp[2] = REF + 16'h0006;
    acq(3);
    chk("toggle off", 32'(pin_o[2]), 32'h0);
    smp[2] = REF;
    acq(1);
    stuck(2, 4, 1'b1);
    $display("test timeouts done");
    // open drain, active low
    straps(1'b1, 1'b1, 1'b1, 1'b0);
    chk("od pins", 32'(pin_o), 32'h1b);
    chk("od value", 32'(key_o), 32'h0);
    chk("od enable", 32'(key_oe_o), 32'h04);
    $display("test drive done");
    // software then pin recalibration
    wb(1'b1, 8'h00, 32'h00010402);
    rdc("ctrl", 8'h00, 32'hffffffff, 32'h00000402);
    smp[3] = REF + 16'h0014;
    acq(1);
    rdc("sw recal", 8'h1c, 32'hffff, 32'(REF + 16'h0014));
    foreach (smp[c])
      smp[c] = REF;
    i_load.pulse(200);
    acq(1);
    for (int c = 0; c < NCH; c++)
    begin
      rdc("pin recal", 8'h10 + 8'(4 * c), 32'hffff, 32'(REF));
    end
    $display("test recalibration done");
    // suppression: the stronger key wins, the weaker waits
    straps(1'b0, 1'b0, 1'b0, 1'b1);
    smp[3] = REF + 16'h0008;
    smp[4] = REF + 16'h000c;
    acq(3);
    chk("strong wins", 32'(pin_o[4:3]), 32'h2);
    smp[4] = REF;
    acq(2);
    chk("weak after", 32'(pin_o[4:3]), 32'h1);
    $display("test suppression done");
    // byte lanes: only the rise divider lane lands, bit 16 lane is off
    wsel = 4'h2;
    wb(1'b1, 8'h00, 32'h00010903);
    wsel = 4'hf;
    rdc("lane", 8'h00, 32'hffffffff, 32'h00000902);
    smp[0] = REF + 16'h0020;
    acq(1);
    rdc("no lane recal", 8'h10, 32'hffff, 32'(REF));
    // frozen clock enable: pending channels ignore samples until it rises
    wb(1'b1, 8'h00, 32'h00010902);
    @(posedge clk_i);
    ce_i <= 1'b0;
    acq(1);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rdc("ce frozen", 8'h10, 32'hffff, 32'(REF));
    acq(1);
    rdc("after ce", 8'h10, 32'hffff, 32'(REF + 16'h0020));
    $display("test lanes and enable done");
    summarize();
  end
endmodule

// ==== tb/tkd_load_model.sv ====
// host side model: pulls up the key lines and pulses recalibrate
`timescale 1ns/1ps
module tkd_load_model
#(
  parameter int NCH = 5
)
(
  // clock
  input wire logic clk_i,
  // key pins from the device
  input wire logic [NCH-1:0] key_i,
  input wire logic [NCH-1:0] key_oe_i,
  // resolved pin levels and recalibrate line
  output logic [NCH-1:0] pin_o,
  output logic recal_n_o
);
  ////////////////////////////////////////////////////////////
  // external pull-up: a released open-drain line reads high
  assign pin_o = (key_oe_i & key_i) | ~key_oe_i;

  // idle high so the device runs from time zero
  initial
  begin
    recal_n_o = 1'b1;
  end

  // low pulse of n clocks; 200 clocks is about 5 us at 40 MHz
  task automatic pulse(input int n);
    @(posedge clk_i);
    recal_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    recal_n_o <= 1'b1;
  endtask
endmodule
